// ### core/hcp_pkg.sv
package hcp_pkg;
   // Avalon byte addresses of the word registers.
   localparam logic [6:0] HCP_ADDR_EXT_HIGH     = 7'h00;
   localparam logic [6:0] HCP_ADDR_EXT_LOW      = 7'h04;
   localparam logic [6:0] HCP_ADDR_STATUS_WR    = 7'h08;
   localparam logic [6:0] HCP_ADDR_STATUS_LOW   = 7'h0C;
   localparam logic [6:0] HCP_ADDR_STATUS_HIGH  = 7'h10;
   localparam logic [6:0] HCP_ADDR_CLEAR        = 7'h14;
   localparam logic [6:0] HCP_ADDR_CONTINUE     = 7'h18;
   localparam logic [6:0] HCP_ADDR_HALT         = 7'h1C;
   localparam logic [6:0] HCP_ADDR_PC_TRAP_LOAD = 7'h20;
   localparam logic [6:0] HCP_ADDR_PC_TRAP_DIS  = 7'h24;
   localparam logic [6:0] HCP_ADDR_PC_LOAD      = 7'h28;
   localparam logic [6:0] HCP_ADDR_PC_HIGH      = 7'h2C;
   localparam logic [6:0] HCP_ADDR_PC_LOW       = 7'h30;
   localparam logic [6:0] HCP_ADDR_DA_TRAP_LOAD = 7'h34;
   localparam logic [6:0] HCP_ADDR_DA_TRAP_DIS  = 7'h38;
   localparam logic [6:0] HCP_ADDR_IRQ_STATUS   = 7'h3C;
   localparam logic [6:0] HCP_ADDR_IRQ_MASK     = 7'h40;
   localparam logic [6:0] HCP_ADDR_CTRL_STATE   = 7'h44;

   // Widths of the host word, the processor word and the event set.
   localparam int HCP_HOST_W = 12;
   localparam int HCP_WORD_W = 16;
   localparam int HCP_HIGH_W = 4;
   localparam int HCP_IRQ_W  = 2;

   // Event bit positions in the interrupt status and mask registers.
   localparam int HCP_IRQ_PC_TRAP = 0;
   localparam int HCP_IRQ_DA_TRAP = 1;

   // Bit positions in the control state read-back word.
   localparam int HCP_CTRL_RUN        = 0;
   localparam int HCP_CTRL_PC_TRAP_EN = 1;
   localparam int HCP_CTRL_DA_TRAP_EN = 2;
   localparam int HCP_CTRL_SWITCH     = 3;

   // Default bit of the status word that reports a trap hit.
   localparam int HCP_TRAP_FOUND_BIT = 0;

   // Reset values.
   localparam logic [15:0] HCP_WORD_RST = 16'h0000;
   localparam logic [11:0] HCP_HOST_RST = 12'h000;
   localparam logic [1:0]  HCP_IRQ_RST  = 2'h0;
   localparam logic [31:0] HCP_BUS_RST  = 32'h0000_0000;
endpackage

// ### core/hcp_host_control_port.sv
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// R1: Host reads and writes 16-bit status word.
// R2: Status read as bits 0-3, then 4-15; the code reads bits 11..0 at 0C and bits 15..12 at 10.
// R3: Clear resets registers, pushdown counter, PC, traps.
// R4: Continue sets the run flip-flop.
// R5: Halt clears the run flip-flop.
// R6: Enabled PC trap halts on match, flags found.
// R7: PC trap load copies extended pair, enables.
// R8: PC trap disable stops PC match halts.
// R9: PC load copies extended pair into PC.
// R10: PC read as high part, then low.
// R11: Enabled data-address trap halts on match, flags.
// R12: Data-address trap load copies pair, enables.
// R13: Data-address trap disable turns trap off.
// R14: Extended high and low loaded from accumulator.
// R15: High holds upper twelve, low lower twelve.
// R16: Value is high low nibble above low twelve.
module hcp_host_control_port
   import hcp_pkg::*;
#(
   parameter int TRAP_FOUND_BIT = HCP_TRAP_FOUND_BIT
) (
   // Clock, reset and clock enable.
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   // Avalon-MM slave.
   input  wire logic [6:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Interrupt.
   output logic             irq_o,
   // Picture processor side.
   input  wire logic        trap_switch_i,
   input  wire logic        proc_pc_we_i,
   input  wire logic [15:0] proc_pc_i,
   input  wire logic        data_address_valid_i,
   input  wire logic [15:0] data_address_bus_i,
   output logic             run_o,
   output logic      [15:0] pc_o,
   output logic      [15:0] status_o,
   output logic             processor_io_clear_o,
   output logic             pushdown_list_clear_o
);

   // Register map, byte offsets on the Avalon side:
   //   00 extended address high, 12 bits, read and write.
   //   04 extended address low, 12 bits, read and write.
   //   08 processor status word, 16 bits, read and write.
   //   0C status read low command, status bits 11..0 on data 11..0.
   //   10 status read high command, status bits 15..12 on data 3..0.
   //   14 clear command, write only.
   //   18 continue command, write only.
   //   1C halt command, write only.
   //   20 program counter trap load, write; a read returns the trap value.
   //   24 program counter trap disable, write only.
   //   28 program counter load, write only.
   //   2C program counter read high, bits 15..12 on data 3..0.
   //   30 program counter read low, bits 11..0 on data 11..0.
   //   34 data address trap load, write; a read returns the trap value.
   //   38 data address trap disable, write only.
   //   3C interrupt status, read, write one to clear.
   //   40 interrupt mask, read and write.
   //   44 control state: run, both trap enables and the panel switch.
   // Reads of write-only or unmapped offsets return zero, and the value
   // written to a command offset is ignored.

   // The trap-found bit must name a bit of the status word.
   if (TRAP_FOUND_BIT < 0 || TRAP_FOUND_BIT >= HCP_WORD_W) begin : g_bad_trap_bit
      $error("TRAP_FOUND_BIT must lie inside the status word");
   end

   typedef struct packed {
      logic [11:0] ext_addr_high_reg;
      logic [11:0] ext_addr_low_reg;
      logic [15:0] status_reg;
      logic        run_reg;
      logic [15:0] pc_reg;
      logic [15:0] pc_trap_reg;
      logic        pc_trap_en_reg;
      logic [15:0] da_trap_reg;
      logic        da_trap_en_reg;
      logic [1:0]  irq_status_reg;
      logic [1:0]  irq_mask_reg;
      logic        ack_reg;
      logic [31:0] rdata_reg;
      logic        io_clear_reg;
      logic        pdl_clear_reg;
   } hcp_state_s;

   localparam hcp_state_s HCP_STATE_RST = '{
      ext_addr_high_reg : HCP_HOST_RST,
      ext_addr_low_reg  : HCP_HOST_RST,
      status_reg        : HCP_WORD_RST,
      run_reg           : 1'b0,
      pc_reg            : HCP_WORD_RST,
      pc_trap_reg       : HCP_WORD_RST,
      pc_trap_en_reg    : 1'b0,
      da_trap_reg       : HCP_WORD_RST,
      da_trap_en_reg    : 1'b0,
      irq_status_reg    : HCP_IRQ_RST,
      irq_mask_reg      : HCP_IRQ_RST,
      ack_reg           : 1'b0,
      rdata_reg         : HCP_BUS_RST,
      io_clear_reg      : 1'b0,
      pdl_clear_reg     : 1'b0
   };

   hcp_state_s st_reg;
   hcp_state_s st_next;

   logic        req;
   logic        wr_take;
   logic [15:0] lane_mask;
   logic [15:0] wdata16;
   logic [15:0] ext_pair;
   logic        pc_hit;
   logic        da_hit;
   logic [1:0]  events;

   // The request is answered one cycle after it appears.
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~st_reg.ack_reg;
   assign wr_take           = avs_write_i & st_reg.ack_reg & ce_i & (|avs_byteenable_i[1:0]);
   assign lane_mask         = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign wdata16           = avs_writedata_i[15:0];

   assign ext_pair = {st_reg.ext_addr_high_reg[HCP_HIGH_W-1:0], st_reg.ext_addr_low_reg}; // R16

   // Traps only fire while the processor runs and the panel switch is up.
   assign pc_hit = st_reg.run_reg & st_reg.pc_trap_en_reg & trap_switch_i
                 & (st_reg.pc_reg == st_reg.pc_trap_reg); // R6 R8
   assign da_hit = st_reg.run_reg & st_reg.da_trap_en_reg & trap_switch_i
                 & data_address_valid_i
                 & (data_address_bus_i == st_reg.da_trap_reg); // R11 R13

   always_comb begin
      events                  = 2'b00;
      events[HCP_IRQ_PC_TRAP] = pc_hit;
      events[HCP_IRQ_DA_TRAP] = da_hit;
   end

   always_comb begin
      st_next               = st_reg;
      st_next.io_clear_reg  = 1'b0;
      st_next.pdl_clear_reg = 1'b0;
      // The answer flop rises for one cycle per request, giving one wait cycle.
      st_next.ack_reg       = req & ~st_reg.ack_reg;

      // The processor's own PC write loses to a host clear or load below.
      if (proc_pc_we_i) begin
         st_next.pc_reg = proc_pc_i;
      end

      // Read data is latched in the wait cycle and held at the answer edge.
      if (req & ~st_reg.ack_reg) begin
         st_next.rdata_reg = HCP_BUS_RST;
         if (avs_read_i) begin
            case (avs_address_i)
               HCP_ADDR_EXT_HIGH: begin
                  st_next.rdata_reg[11:0] = st_reg.ext_addr_high_reg;
               end
               HCP_ADDR_EXT_LOW: begin
                  st_next.rdata_reg[11:0] = st_reg.ext_addr_low_reg;
               end
               HCP_ADDR_STATUS_WR: begin
                  st_next.rdata_reg[15:0] = st_reg.status_reg; // R1
               end
               HCP_ADDR_STATUS_LOW: begin
                  st_next.rdata_reg[11:0] = st_reg.status_reg[11:0]; // R2
               end
               HCP_ADDR_STATUS_HIGH: begin
                  st_next.rdata_reg[3:0] = st_reg.status_reg[15:12]; // R2
               end
               HCP_ADDR_PC_TRAP_LOAD: begin
                  st_next.rdata_reg[15:0] = st_reg.pc_trap_reg;
               end
               HCP_ADDR_PC_HIGH: begin
                  st_next.rdata_reg[3:0] = st_reg.pc_reg[15:12]; // R10
               end
               HCP_ADDR_PC_LOW: begin
                  st_next.rdata_reg[11:0] = st_reg.pc_reg[11:0]; // R10
               end
               HCP_ADDR_DA_TRAP_LOAD: begin
                  st_next.rdata_reg[15:0] = st_reg.da_trap_reg;
               end
               HCP_ADDR_IRQ_STATUS: begin
                  st_next.rdata_reg[1:0] = st_reg.irq_status_reg;
               end
               HCP_ADDR_IRQ_MASK: begin
                  st_next.rdata_reg[1:0] = st_reg.irq_mask_reg;
               end
               HCP_ADDR_CTRL_STATE: begin
                  st_next.rdata_reg[HCP_CTRL_RUN]        = st_reg.run_reg;
                  st_next.rdata_reg[HCP_CTRL_PC_TRAP_EN] = st_reg.pc_trap_en_reg;
                  st_next.rdata_reg[HCP_CTRL_DA_TRAP_EN] = st_reg.da_trap_en_reg;
                  st_next.rdata_reg[HCP_CTRL_SWITCH]     = trap_switch_i;
               end
               default: begin
                  st_next.rdata_reg = HCP_BUS_RST;
               end
            endcase
         end
      end

      // Writes act at the answer edge only, and only with a low byte lane enabled.
      if (wr_take) begin
         case (avs_address_i)
            HCP_ADDR_EXT_HIGH: begin
               st_next.ext_addr_high_reg = avs_writedata_i[11:0]; // R14 R15
            end
            HCP_ADDR_EXT_LOW: begin
               st_next.ext_addr_low_reg = avs_writedata_i[11:0]; // R14 R15
            end
            HCP_ADDR_STATUS_WR: begin
               st_next.status_reg = (st_reg.status_reg & ~lane_mask)
                                  | (wdata16 & lane_mask); // R1
            end
            HCP_ADDR_CLEAR: begin
               st_next.status_reg     = HCP_WORD_RST; // R3
               st_next.run_reg        = 1'b0;
               st_next.pc_reg         = HCP_WORD_RST;
               st_next.pc_trap_en_reg = 1'b0;
               st_next.da_trap_en_reg = 1'b0;
               st_next.io_clear_reg   = 1'b1;
               st_next.pdl_clear_reg  = 1'b1;
            end
            HCP_ADDR_CONTINUE: begin
               st_next.run_reg = 1'b1; // R4
            end
            HCP_ADDR_HALT: begin
               st_next.run_reg = 1'b0; // R5
            end
            HCP_ADDR_PC_TRAP_LOAD: begin
               st_next.pc_trap_reg    = ext_pair; // R7
               st_next.pc_trap_en_reg = 1'b1;
            end
            HCP_ADDR_PC_TRAP_DIS: begin
               st_next.pc_trap_en_reg = 1'b0; // R8
            end
            HCP_ADDR_PC_LOAD: begin
               st_next.pc_reg = ext_pair; // R9
            end
            HCP_ADDR_DA_TRAP_LOAD: begin
               st_next.da_trap_reg    = ext_pair; // R12
               st_next.da_trap_en_reg = 1'b1;
            end
            HCP_ADDR_DA_TRAP_DIS: begin
               st_next.da_trap_en_reg = 1'b0; // R13
            end
            HCP_ADDR_IRQ_STATUS: begin
               st_next.irq_status_reg = st_reg.irq_status_reg & ~avs_writedata_i[1:0];
            end
            HCP_ADDR_IRQ_MASK: begin
               st_next.irq_mask_reg = avs_writedata_i[1:0];
            end
            default: begin
               st_next.run_reg = st_next.run_reg;
            end
         endcase
      end

      // A trap hit overrides a continue in the same cycle and beats any clear.
      if (pc_hit | da_hit) begin
         st_next.run_reg                    = 1'b0; // R6 R11
         st_next.status_reg[TRAP_FOUND_BIT] = 1'b1; // R6 R11
      end
      st_next.irq_status_reg = st_next.irq_status_reg | events;

      // Clock enable low freezes every bit of state, the bus handshake included.
      if (!ce_i) begin
         st_next = st_reg;
      end
   end

   // Reset is synchronous and does not wait for the clock enable.
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         st_reg <= HCP_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign avs_readdata_o        = st_reg.rdata_reg;
   assign irq_o                 = |(st_reg.irq_status_reg & st_reg.irq_mask_reg);
   assign run_o                 = st_reg.run_reg;
   assign pc_o                  = st_reg.pc_reg;
   assign status_o              = st_reg.status_reg;
   assign processor_io_clear_o  = st_reg.io_clear_reg; // R3
   assign pushdown_list_clear_o = st_reg.pdl_clear_reg; // R3

endmodule // hcp_host_control_port

// ### sim/hcp_properties.sv
`timescale 1ns/1ns
module hcp_properties
   import hcp_pkg::*;
#(
   parameter int TRAP_FOUND_BIT = HCP_TRAP_FOUND_BIT
) (
   // Clock, reset and bus.
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   input  wire logic [6:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_readdata_o,
   input  wire logic        avs_waitrequest_o,
   // Processor side.
   input  wire logic        trap_switch_i,
   input  wire logic        data_address_valid_i,
   input  wire logic [15:0] data_address_bus_i,
   input  wire logic        run_o,
   input  wire logic [15:0] pc_o,
   input  wire logic [15:0] status_o,
   input  wire logic        processor_io_clear_o,
   input  wire logic        pushdown_list_clear_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   wire         wacc = avs_write_i && !avs_waitrequest_o && ce_i && (|avs_byteenable_i[1:0]);
   wire         rreq = avs_read_i && avs_waitrequest_o && ce_i;
   wire [11:0]  pc_lo = pc_o[11:0];
   wire [3:0]   st_hi = status_o[15:12];
   logic [11:0] eh;
   logic [11:0] el;
   logic [15:0] pct;
   logic [15:0] dat;
   logic        pce;
   logic        dae;
   // Shadow of the extended pair and the trap state, updated at each accepted write.
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         {eh, el, pct, dat, pce, dae} <= 58'h0;
      end else if (wacc) begin
         case (avs_address_i)
            HCP_ADDR_EXT_HIGH:     eh <= avs_writedata_i[11:0];
            HCP_ADDR_EXT_LOW:      el <= avs_writedata_i[11:0];
            HCP_ADDR_PC_TRAP_LOAD: {pce, pct} <= {1'b1, eh[3:0], el};
            HCP_ADDR_DA_TRAP_LOAD: {dae, dat} <= {1'b1, eh[3:0], el};
            HCP_ADDR_PC_TRAP_DIS:  pce <= 1'b0;
            HCP_ADDR_DA_TRAP_DIS:  dae <= 1'b0;
            HCP_ADDR_CLEAR:        {pce, dae} <= 2'h0;
            default:               ;
         endcase
      end
   end
   sequence s_clr_pulse;
      processor_io_clear_o && pushdown_list_clear_o && !run_o && pc_o == 16'h0000 ##1
         !processor_io_clear_o && !pushdown_list_clear_o;
   endsequence
   sequence s_trap_hit;
      !run_o && status_o[TRAP_FOUND_BIT];
   endsequence
   chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
      |=> !avs_waitrequest_o) else $error("no answer after one wait cycle");
   chk_continue_run: assert property (wacc && avs_address_i == HCP_ADDR_CONTINUE && !run_o
      |=> run_o) else $error("continue did not start");
   chk_halt_run: assert property (wacc && avs_address_i == HCP_ADDR_HALT
      |=> !run_o) else $error("halt did not stop");
   chk_clear_pulse: assert property (wacc && avs_address_i == HCP_ADDR_CLEAR
      |=> s_clr_pulse) else $error("clear effect wrong");
   chk_pc_load: assert property (wacc && avs_address_i == HCP_ADDR_PC_LOAD
      |=> pc_o == {eh[3:0], el}) else $error("pc load wrong");
   chk_pc_read: assert property (rreq && avs_address_i == HCP_ADDR_PC_LOW
      |=> avs_readdata_o == {20'h0_0000, $past(pc_lo)}) else $error("pc low read wrong");
   chk_status_read: assert property (rreq && avs_address_i == HCP_ADDR_STATUS_HIGH
      |=> avs_readdata_o == {28'h000_0000, $past(st_hi)}) else $error("status high read wrong");
   chk_pc_trap: assert property (run_o && pce && trap_switch_i && pc_o == pct
      |=> s_trap_hit) else $error("pc trap missed");
   chk_da_trap: assert property (run_o && dae && trap_switch_i && data_address_valid_i
      && data_address_bus_i == dat |=> s_trap_hit) else $error("data trap missed");
endmodule // hcp_properties

bind hcp_host_control_port hcp_properties #(.TRAP_FOUND_BIT(TRAP_FOUND_BIT)) i_hcp_properties (.*);

// ### sim/hcp_proc_model.sv
`timescale 1ns/1ns
module hcp_proc_model (
   // Clock.
   input  wire logic        mclk_i,
   // Processor state seen from the port.
   input  wire logic        run_i,
   input  wire logic [15:0] pc_i,
   // Processor activity.
   output logic             pc_we_o,
   output logic      [15:0] pc_next_o,
   output logic             da_valid_o,
   output logic      [15:0] da_bus_o
);
   logic [15:0] last_da = 16'h0000;
   // A running processor steps its PC each cycle; an idle bus toggles so no stale match occurs.
   always @(posedge mclk_i) last_da <= da_bus_o;
   assign pc_we_o = run_i;
   assign pc_next_o = pc_i + 16'h0001;
   assign da_valid_o = run_i;
   assign da_bus_o = run_i ? pc_i + 16'h0100 : ~last_da;
endmodule // hcp_proc_model

// ### sim/tb_hcp_host_control_port.sv
`timescale 1ns/1ns
module tb_hcp_host_control_port
   import hcp_pkg::*;
;
   logic        mclk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [6:0]  addr = 7'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic        sw = 1'b1;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, q;
   logic        wreq, irq, run, pcwe, dav, processor_io_clear, pdclr;
   logic [15:0] pc, pcn, dab, stat;
   int          fails = 0;
   int          checks = 0;
   always #10 mclk_i = ~mclk_i;
   hcp_host_control_port i_hcp_host_control_port (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .ce_i(1'b1), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .irq_o(irq), .trap_switch_i(sw), .proc_pc_we_i(pcwe),
      .proc_pc_i(pcn), .data_address_valid_i(dav), .data_address_bus_i(dab), .run_o(run),
      .pc_o(pc), .status_o(stat), .processor_io_clear_o(processor_io_clear), .pushdown_list_clear_o(pdclr));
   hcp_proc_model i_hcp_proc_model (.mclk_i(mclk_i), .run_i(run), .pc_i(pc), .pc_we_o(pcwe),
      .pc_next_o(pcn), .da_valid_o(dav), .da_bus_o(dab));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic [6:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      do begin
         @(posedge mclk_i);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic put(input logic [6:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
      @(negedge mclk_i);
   endtask
   task automatic rdc(input string n, input logic [6:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(n, e, q);
   endtask
   task automatic ext(input logic [11:0] l);
      put(HCP_ADDR_EXT_HIGH, 32'h0);
      put(HCP_ADDR_EXT_LOW, {20'h0, l});
   endtask
   task automatic wait_halt();
      for (int n = 0; n < 60 && run !== 1'b0; n++) @(negedge mclk_i);
      chk("run_o", 32'h0, {31'h0, run});
   endtask
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge mclk_i);
      fails++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      rdc("ctrl", HCP_ADDR_CTRL_STATE, 32'h8);
      rdc("unmapped", 7'h48, 32'h0);
      put(HCP_ADDR_STATUS_WR, 32'h1234);
      chk("status_o", 32'h1234, {16'h0, stat});
      rdc("status high", HCP_ADDR_STATUS_HIGH, 32'h1);
      rdc("status low", HCP_ADDR_STATUS_LOW, 32'h234);
      $display("test status done");
      put(HCP_ADDR_EXT_HIGH, 32'hABC);
      put(HCP_ADDR_EXT_LOW, 32'hDEF);
      rdc("ext high", HCP_ADDR_EXT_HIGH, 32'hABC);
      rdc("ext low", HCP_ADDR_EXT_LOW, 32'hDEF);
      put(HCP_ADDR_PC_LOAD, 32'h0);
      chk("pc_o", 32'hCDEF, {16'h0, pc});
      rdc("pc high", HCP_ADDR_PC_HIGH, 32'hC);
      rdc("pc low", HCP_ADDR_PC_LOW, 32'hDEF);
      put(HCP_ADDR_CONTINUE, 32'h0);
      chk("run_o", 32'h1, {31'h0, run});
      put(HCP_ADDR_HALT, 32'h0);
      chk("run_o", 32'h0, {31'h0, run});
      $display("test pc and run done");
      put(HCP_ADDR_IRQ_MASK, 32'h3);
      ext(12'h010);
      put(HCP_ADDR_PC_LOAD, 32'h0);
      ext(12'h014);
      put(HCP_ADDR_PC_TRAP_LOAD, 32'h0);
      rdc("ctrl", HCP_ADDR_CTRL_STATE, 32'hA);
      put(HCP_ADDR_CONTINUE, 32'h0);
      wait_halt();
      chk("trap found", 32'h1, {31'h0, stat[HCP_TRAP_FOUND_BIT]});
      rdc("irq status", HCP_ADDR_IRQ_STATUS, 32'h1);
      chk("irq_o", 32'h1, {31'h0, irq});
      put(HCP_ADDR_IRQ_MASK, 32'h0);
      chk("irq_o", 32'h0, {31'h0, irq});
      put(HCP_ADDR_IRQ_MASK, 32'h3);
      put(HCP_ADDR_IRQ_STATUS, 32'h3);
      chk("irq_o", 32'h0, {31'h0, irq});
      $display("test pc trap done");
      put(HCP_ADDR_CLEAR, 32'h0);
      chk("io clear", 32'h1, {31'h0, processor_io_clear});
      chk("pdl clear", 32'h1, {31'h0, pdclr});
      chk("pc_o", 32'h0, {16'h0, pc});
      chk("status_o", 32'h0, {16'h0, stat});
      rdc("ctrl", HCP_ADDR_CTRL_STATE, 32'h8);
      ext(12'h010);
      put(HCP_ADDR_PC_LOAD, 32'h0);
      ext(12'h014);
      put(HCP_ADDR_PC_TRAP_LOAD, 32'h0);
      put(HCP_ADDR_PC_TRAP_DIS, 32'h0);
      put(HCP_ADDR_CONTINUE, 32'h0);
      repeat (15) @(negedge mclk_i);
      chk("run_o", 32'h1, {31'h0, run});
      put(HCP_ADDR_HALT, 32'h0);
      $display("test clear and disable done");
      ext(12'h010);
      put(HCP_ADDR_PC_LOAD, 32'h0);
      ext(12'h118);
      put(HCP_ADDR_DA_TRAP_LOAD, 32'h0);
      rdc("ctrl", HCP_ADDR_CTRL_STATE, 32'hC);
      put(HCP_ADDR_CONTINUE, 32'h0);
      wait_halt();
      rdc("irq status", HCP_ADDR_IRQ_STATUS, 32'h2);
      put(HCP_ADDR_DA_TRAP_DIS, 32'h0);
      rdc("ctrl", HCP_ADDR_CTRL_STATE, 32'h8);
      $display("test data trap done");
      sw <= 1'b0;
      ext(12'h010);
      put(HCP_ADDR_PC_LOAD, 32'h0);
      ext(12'h014);
      put(HCP_ADDR_PC_TRAP_LOAD, 32'h0);
      put(HCP_ADDR_CONTINUE, 32'h0);
      repeat (15) @(negedge mclk_i);
      chk("run_o", 32'h1, {31'h0, run});
      rdc("ctrl", HCP_ADDR_CTRL_STATE, 32'h3);
      put(HCP_ADDR_HALT, 32'h0);
      $display("test panel switch done");
      summarize();
   end
endmodule // tb_hcp_host_control_port
